// ---- rtl/cgn_pkg.sv ----
// Package: offsets, reset values and state codes of the clock generator config bank
package cgn_pkg;

	// ----------------------------------------------------------------
	// Byte offsets of the bank
	// ----------------------------------------------------------------
	localparam logic [6:0] CGN_OFF_AMP = 7'h06;
	localparam logic [6:0] CGN_OFF_ID = 7'h07;
	localparam logic [6:0] CGN_OFF_LEN = 7'h08;
	localparam logic [6:0] CGN_OFF_SRC = 7'h09;
	localparam logic [6:0] CGN_OFF_RSVD = 7'h0A;
	localparam logic [6:0] CGN_OFF_SLEW = 7'h0B;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] CGN_RST_AMP = 8'h00;
	localparam logic [7:0] CGN_RST_LEN = 8'h0F;
	localparam logic [7:0] CGN_RST_SRC = 8'hE0;
	localparam logic [7:0] CGN_RST_RSVD = 8'h00;
	localparam logic [7:0] CGN_RST_SLEW = 8'hB7;

	// ----------------------------------------------------------------
	// Field positions and fixed codes
	// ----------------------------------------------------------------
	localparam int CGN_POS_HOST_SWING = 6;
	localparam int CGN_POS_SOURCE_SWING = 4;
	localparam int CGN_POS_DOT_SWING = 2;
	localparam int CGN_POS_STORAGE_SWING = 0;
	localparam int CGN_POS_REF_SLEW = 5;
	localparam int CGN_POS_QH_SLEW = 2;
	localparam int CGN_POS_EN = 5;
	localparam logic [2:0] CGN_SLEW_WEAK = 3'h7;
	localparam logic [7:0] CGN_IDLE_BYTE = 8'hFF;
	localparam logic [3:0] CGN_BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// Serial engine states, Gray coded along the usual path
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CGN_IDLE = 3'h0,
		CGN_RX = 3'h1,
		CGN_ACK = 3'h3,
		CGN_TX = 3'h2,
		CGN_RACK = 3'h6,
		CGN_WAIT = 3'h7
	} cgn_state_t;

	typedef enum logic [1:0] {
		CGN_PH_ADDR = 2'h0,
		CGN_PH_CMD = 2'h1,
		CGN_PH_COUNT = 2'h2,
		CGN_PH_DATA = 2'h3
	} cgn_phase_t;

endpackage : cgn_pkg

// ---- rtl/cgn_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
module cgn_sync #(
	parameter int W = 1
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} cgn_sync_t;

	cgn_sync_t st;
	cgn_sync_t next_st;

	if (W < 1) begin : g_chk
		$error("cgn_sync: W must be at least 1");
	end

	always_comb begin
		next_st.meta = i_d;
		next_st.q = st.meta;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_q = st.q;
endmodule : cgn_sync

// ---- rtl/cgn_out_gate.sv ----
// Output clock gating on the link clock: enable, free-run and stop control
`timescale 1ns/1ps
module cgn_out_gate #(
	parameter int NOUT = 5
) (
	input wire logic i_link_clock,
	input wire logic i_resetn,
	input wire logic [NOUT-1:0] i_enable,
	input wire logic [NOUT-1:0] i_stoppable,
	input wire logic [NOUT-1:0] i_stop_n,
	output logic [NOUT-1:0] o_clock
);
	typedef struct packed {
		logic [NOUT-1:0] tgl;
	} cgn_gate_t;

	cgn_gate_t st;
	cgn_gate_t next_st;
	logic [NOUT-1:0] en_s;
	logic [NOUT-1:0] stp_s;
	logic [NOUT-1:0] stop_n_s;
	logic [NOUT-1:0] run;

	if (NOUT < 1) begin : g_chk
		$error("cgn_out_gate: NOUT must be at least 1");
	end

	cgn_sync #(.W(3 * NOUT)) u_sync (
		.i_clock(i_link_clock),
		.i_resetn(i_resetn),
		.i_d({i_enable, i_stoppable, i_stop_n}),
		.o_q({en_s, stp_s, stop_n_s})
	);

	// Stoppable outputs halt on stop, free-running ones ignore it
	assign run = en_s & ~(stp_s & ~stop_n_s);

	always_comb begin
		next_st.tgl = st.tgl ^ run;
	end

	always_ff @(posedge i_link_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_clock = st.tgl;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	en_gate_a: assert property (@(posedge i_link_clock) disable iff (!i_resetn)
		!en_s[NOUT-1] |=> $stable(o_clock[NOUT-1]))
		else $error("disabled output toggled");
	stop_halt_a: assert property (@(posedge i_link_clock) disable iff (!i_resetn)
		stp_s[0] && !stop_n_s[0] |=> $stable(o_clock[0]))
		else $error("stoppable output ran during stop");
	free_run_a: assert property (@(posedge i_link_clock) disable iff (!i_resetn)
		en_s[1] && !stp_s[1] |=> o_clock[1] != $past(o_clock[1]))
		else $error("free running output halted");
	stop_seen_c: cover property (@(posedge i_link_clock) disable iff (!i_resetn)
		stp_s[0] && !stop_n_s[0] ##1 stop_n_s[0]);
endmodule : cgn_out_gate

// ---- rtl/cgn_config_bank.sv ----
// Config bytes 6..11 of the clock generator with their serial management port
`timescale 1ns/1ps
module cgn_config_bank
	import cgn_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h69,
	parameter logic [3:0] REV_CODE = 4'h1, // Arbitrary value
	parameter logic [3:0] MAKER_CODE = 4'h5 // Arbitrary value
) (
	input wire logic I_CLOCK,
	input wire logic I_RESETN,
	input wire logic I_LINK_CLOCK,
	input wire logic I_SCL,
	input wire logic I_SDA,
	output logic O_SDA_OUT,
	output logic O_SDA_OE,
	input wire logic I_WIRELESS_MODE,
	input wire logic I_SOURCE_STOP_N,
	input wire logic I_BUS_STOP_N,
	output logic [1:0] O_HOST_CLOCK_SWING,
	output logic [1:0] O_SOURCE_CLOCK_SWING,
	output logic [1:0] O_DOT_CLOCK_SWING,
	output logic [1:0] O_STORAGE_CLOCK_SWING,
	output logic [2:0] O_REF_SLEW_CODE,
	output logic [2:0] O_QUARTER_HUNDRED_SLEW_CODE,
	output logic [2:0] O_USB_ALT_SLEW_CODE,
	output logic O_SOURCE_OUT5,
	output logic O_SOURCE_OUT4,
	output logic O_SOURCE_OUT3,
	output logic O_BUS_CLOCK_OUT0,
	output logic O_BUS_CLOCK_FIXED
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		cgn_state_t state;
		cgn_phase_t phase;
		logic scl_d;
		logic sda_d;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic reading;
		logic block_mode;
		logic ack_ok;
		logic [6:0] ptr;
		logic [7:0] sent;
		logic sda_oe;
		logic [7:0] amp;
		logic [7:0] len;
		logic [7:0] src;
		logic [7:0] slew;
		logic [7:0] o_amp;
		logic [2:0] o_ref;
		logic [2:0] o_qh;
		logic [2:0] o_usb;
	} cgn_bank_t;

	cgn_bank_t st;
	cgn_bank_t next_st;
	logic scl_s;
	logic sda_s;
	logic wl_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] tx_byte;
	logic tx_is_count;
	logic [4:0] gate_clk;

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] cgn_read(input logic [6:0] a, input cgn_bank_t s);
		logic [7:0] d;
		d = 8'h00;
		if (a == CGN_OFF_AMP) begin
			d = s.amp;
		end else if (a == CGN_OFF_ID) begin
			d = {REV_CODE, MAKER_CODE};
		end else if (a == CGN_OFF_LEN) begin
			d = s.len;
		end else if (a == CGN_OFF_SRC) begin
			d = s.src;
		end else if (a == CGN_OFF_RSVD) begin
			d = CGN_RST_RSVD;
		end else if (a == CGN_OFF_SLEW) begin
			d = s.slew;
		end
		return d;
	endfunction : cgn_read

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	cgn_sync #(.W(3)) u_pin_sync (
		.i_clock(I_CLOCK),
		.i_resetn(I_RESETN),
		.i_d({I_SCL, I_SDA, I_WIRELESS_MODE}),
		.o_q({scl_s, sda_s, wl_s})
	);

	assign scl_rise = scl_s & ~st.scl_d;
	assign scl_fall = ~scl_s & st.scl_d;
	assign start_seen = scl_s & st.scl_d & st.sda_d & ~sda_s;
	assign stop_seen = scl_s & st.scl_d & ~st.sda_d & sda_s;

	// Block read sends the length first, then bytes up to that length
	assign tx_is_count = st.block_mode && (st.sent == 8'h00);
	always_comb begin
		if (tx_is_count) begin
			tx_byte = st.len;
		end else if (st.block_mode && (st.sent > st.len)) begin
			tx_byte = CGN_IDLE_BYTE;
		end else begin
			tx_byte = cgn_read(st.ptr, st);
		end
	end

	// ----------------------------------------------------------------
	// Serial engine and register file
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.scl_d = scl_s;
		next_st.sda_d = sda_s;
		if (stop_seen) begin
			next_st.state = CGN_IDLE;
			next_st.sda_oe = 1'b0;
		end else if (start_seen) begin
			next_st.state = CGN_RX;
			next_st.phase = CGN_PH_ADDR;
			next_st.bitcnt = 4'h0;
			next_st.sent = 8'h00;
			next_st.sda_oe = 1'b0;
		end else begin
			case (st.state)
				CGN_RX: begin
					if (scl_rise) begin
						next_st.shift = {st.shift[6:0], sda_s};
						next_st.bitcnt = st.bitcnt + 4'h1;
					end else if (scl_fall && st.bitcnt == CGN_BITS_PER_BYTE) begin
						next_st.bitcnt = 4'h0;
						next_st.state = CGN_ACK;
						next_st.sda_oe = 1'b1;
						case (st.phase)
							CGN_PH_ADDR: begin
								next_st.reading = st.shift[0];
								next_st.phase = CGN_PH_CMD;
								if (st.shift[7:1] != SLAVE_ADDR) begin
									next_st.state = CGN_WAIT;
									next_st.sda_oe = 1'b0;
								end
							end
							CGN_PH_CMD: begin
								next_st.ptr = st.shift[6:0];
								next_st.block_mode = ~st.shift[7];
								next_st.phase = st.shift[7] ? CGN_PH_DATA : CGN_PH_COUNT;
							end
							CGN_PH_COUNT: begin
								next_st.phase = CGN_PH_DATA;
							end
							default: begin
								next_st.ptr = st.ptr + 7'h01;
								if (st.ptr == CGN_OFF_AMP) begin
									next_st.amp = st.shift;
								end else if (st.ptr == CGN_OFF_LEN) begin
									next_st.len = st.shift;
								end else if (st.ptr == CGN_OFF_SRC) begin
									next_st.src = st.shift;
								end else if (st.ptr == CGN_OFF_SLEW) begin
									next_st.slew = st.shift;
								end
							end
						endcase
					end
				end
				CGN_ACK: begin
					if (scl_fall) begin
						if (st.reading) begin
							next_st.state = CGN_TX;
							next_st.shift = tx_byte;
							next_st.sda_oe = ~tx_byte[7];
							next_st.sent = st.sent + 8'h01;
							if (!tx_is_count) begin
								next_st.ptr = st.ptr + 7'h01;
							end
						end else begin
							next_st.state = CGN_RX;
							next_st.sda_oe = 1'b0;
						end
					end
				end
				CGN_TX: begin
					if (scl_fall) begin
						next_st.bitcnt = st.bitcnt + 4'h1;
						if (st.bitcnt == 4'h7) begin
							next_st.bitcnt = 4'h0;
							next_st.state = CGN_RACK;
							next_st.sda_oe = 1'b0;
						end else begin
							next_st.shift = {st.shift[6:0], 1'b0};
							next_st.sda_oe = ~st.shift[6];
						end
					end
				end
				CGN_RACK: begin
					if (scl_rise) begin
						next_st.ack_ok = ~sda_s;
					end else if (scl_fall) begin
						if (st.ack_ok) begin
							next_st.state = CGN_TX;
							next_st.shift = tx_byte;
							next_st.sda_oe = ~tx_byte[7];
							next_st.sent = st.sent + 8'h01;
							if (!tx_is_count) begin
								next_st.ptr = st.ptr + 7'h01;
							end
						end else begin
							next_st.state = CGN_WAIT;
						end
					end
				end
				default: begin
					next_st.sda_oe = 1'b0;
				end
			endcase
		end
		// Output copies of the settings
		next_st.o_amp = st.amp;
		next_st.o_ref = wl_s ? CGN_SLEW_WEAK : st.slew[CGN_POS_REF_SLEW +: 3];
		next_st.o_qh = wl_s ? CGN_SLEW_WEAK : st.slew[CGN_POS_QH_SLEW +: 3];
		next_st.o_usb = wl_s ? CGN_SLEW_WEAK : {st.slew[1], 1'b0, st.slew[0]};
	end

	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			st <= '0;
			st.state <= CGN_IDLE;
			st.scl_d <= 1'b1;
			st.sda_d <= 1'b1;
			st.amp <= CGN_RST_AMP;
			st.len <= CGN_RST_LEN;
			st.src <= CGN_RST_SRC;
			st.slew <= CGN_RST_SLEW;
			st.o_amp <= CGN_RST_AMP;
			st.o_ref <= CGN_RST_SLEW[CGN_POS_REF_SLEW +: 3];
			st.o_qh <= CGN_RST_SLEW[CGN_POS_QH_SLEW +: 3];
			st.o_usb <= {CGN_RST_SLEW[1], 1'b0, CGN_RST_SLEW[0]};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Output clocks on the link clock
	// ----------------------------------------------------------------
	cgn_out_gate #(.NOUT(5)) u_gate (
		.i_link_clock(I_LINK_CLOCK),
		.i_resetn(I_RESETN),
		.i_enable({st.src[CGN_POS_EN +: 3], 2'h3}),
		.i_stoppable(st.src[4:0]),
		.i_stop_n({{3{I_SOURCE_STOP_N}}, {2{I_BUS_STOP_N}}}),
		.o_clock(gate_clk)
	);

	assign O_SOURCE_OUT5 = gate_clk[4];
	assign O_SOURCE_OUT4 = gate_clk[3];
	assign O_SOURCE_OUT3 = gate_clk[2];
	assign O_BUS_CLOCK_OUT0 = gate_clk[1];
	assign O_BUS_CLOCK_FIXED = gate_clk[0];
	assign O_SDA_OUT = 1'b0;
	assign O_SDA_OE = st.sda_oe;
	assign O_HOST_CLOCK_SWING = st.o_amp[CGN_POS_HOST_SWING +: 2];
	assign O_SOURCE_CLOCK_SWING = st.o_amp[CGN_POS_SOURCE_SWING +: 2];
	assign O_DOT_CLOCK_SWING = st.o_amp[CGN_POS_DOT_SWING +: 2];
	assign O_STORAGE_CLOCK_SWING = st.o_amp[CGN_POS_STORAGE_SWING +: 2];
	assign O_REF_SLEW_CODE = st.o_ref;
	assign O_QUARTER_HUNDRED_SLEW_CODE = st.o_qh;
	assign O_USB_ALT_SLEW_CODE = st.o_usb;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESETN);

	wire tx_load = (st.state == CGN_ACK && st.reading || st.state == CGN_RACK && st.ack_ok)
		&& scl_fall && !start_seen && !stop_seen;

	amp_follow_a: assert property ($changed(st.amp) |-> ##2
		O_HOST_CLOCK_SWING == $past(st.amp[7:6], 2) && O_STORAGE_CLOCK_SWING == $past(st.amp[1:0], 2))
		else $error("swing outputs do not follow register");
	id_fixed_a: assert property (tx_load && !tx_is_count && st.ptr == CGN_OFF_ID
		&& !(st.block_mode && st.sent > st.len) |=> st.shift == {REV_CODE, MAKER_CODE})
		else $error("identity byte wrong");
	len_reset_a: assert property (@(posedge I_CLOCK) $rose(I_RESETN) |-> st.len == CGN_RST_LEN)
		else $error("read length not fifteen after reset");
	count_first_a: assert property (tx_load && tx_is_count |=> st.shift == $past(st.len))
		else $error("block read did not start with length");
	rsvd_zero_a: assert property (tx_load && !tx_is_count && st.ptr == CGN_OFF_RSVD
		&& !(st.block_mode && st.sent > st.len) |=> st.shift == 8'h00)
		else $error("reserved byte not zero");
	slew_weak_a: assert property (wl_s |=> O_REF_SLEW_CODE == CGN_SLEW_WEAK
		&& O_QUARTER_HUNDRED_SLEW_CODE == CGN_SLEW_WEAK && O_USB_ALT_SLEW_CODE == CGN_SLEW_WEAK)
		else $error("wireless mode did not force weakest slew");
	slew_field_a: assert property (!wl_s |=>
		O_QUARTER_HUNDRED_SLEW_CODE == $past(st.slew[4:2])
		&& O_REF_SLEW_CODE == $past(st.slew[7:5]))
		else $error("slew outputs do not follow register");
	src_write_c: cover property ($changed(st.src));
	block_read_c: cover property (tx_load && tx_is_count ##[1:400] tx_load && !tx_is_count);
endmodule : cgn_config_bank

// ---- tb/cgn_host_model.sv ----
// Management bus host model: open-drain clock and data with byte-level tasks
`timescale 1ns/1ps
module cgn_host_model (
	input wire logic i_clock,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// ----------------------------------------------------------------
	// Idle bus, both lines released
	// ----------------------------------------------------------------
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// ----------------------------------------------------------------
	// Bus phases of eight system clocks, each bit led by a three-clock data hold
	// ----------------------------------------------------------------
	task automatic wt(input int n);
		repeat (n) @(negedge i_clock);
	endtask : wt

	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		wt(3);
		o_sda = b;
		wt(8);
		o_scl = 1'b1;
		wt(8);
		r = i_sda;
		o_scl = 1'b0;
	endtask : bit_io

	// Start or repeated start
	task automatic start();
		wt(3);
		o_sda = 1'b1;
		wt(8);
		o_scl = 1'b1;
		wt(8);
		o_sda = 1'b0;
		wt(8);
		o_scl = 1'b0;
	endtask : start

	task automatic stop();
		wt(3);
		o_sda = 1'b0;
		wt(8);
		o_scl = 1'b1;
		wt(8);
		o_sda = 1'b1;
		wt(8);
	endtask : stop

	task automatic tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : tx

	// Last byte of a read is answered by releasing the line
	task automatic rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask : rx
endmodule : cgn_host_model

// ---- tb/test_cgn_config_bank.sv ----
// Self-checking bench of the config bank: registers, slew codes, block read, gating
`timescale 1ns/1ps
module test_cgn_config_bank
	import cgn_pkg::*;
;
	localparam logic [3:0] REV = 4'h3; // Arbitrary value
	localparam logic [3:0] MAKER = 4'hA; // Arbitrary value
	logic clk, rstn, lclk, wl, sstop_n, bstop_n, scl, hsda, ack;
	wire sda_out, sda_oe;
	wire sda = hsda & ~(sda_oe & ~sda_out);
	logic [1:0] hsw, ssw, dsw, stsw;
	logic [2:0] rsl, qsl, usl;
	wire [4:0] oc;
	logic [4:0] t;
	logic [7:0] d, v, b;
	logic [7:0] rb [0:7];
	logic [7:0] ex [0:5];
	int err_count, comparisons;
	int seed = 83279;

	cgn_config_bank #(.REV_CODE(REV), .MAKER_CODE(MAKER)) i_cgn_config_bank (
		.I_CLOCK(clk), .I_RESETN(rstn), .I_LINK_CLOCK(lclk), .I_SCL(scl), .I_SDA(sda),
		.O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_WIRELESS_MODE(wl),
		.I_SOURCE_STOP_N(sstop_n), .I_BUS_STOP_N(bstop_n),
		.O_HOST_CLOCK_SWING(hsw), .O_SOURCE_CLOCK_SWING(ssw), .O_DOT_CLOCK_SWING(dsw),
		.O_STORAGE_CLOCK_SWING(stsw), .O_REF_SLEW_CODE(rsl),
		.O_QUARTER_HUNDRED_SLEW_CODE(qsl), .O_USB_ALT_SLEW_CODE(usl),
		.O_SOURCE_OUT5(oc[4]), .O_SOURCE_OUT4(oc[3]), .O_SOURCE_OUT3(oc[2]),
		.O_BUS_CLOCK_OUT0(oc[1]), .O_BUS_CLOCK_FIXED(oc[0]));

	cgn_host_model i_cgn_host_model (.i_clock(clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));

	// ----------------------------------------------------------------
	// Clocks, phase unrelated
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #16 lclk = ~lclk;
	end

	// ----------------------------------------------------------------
	// Expectations, comparison and bus tasks
	// ----------------------------------------------------------------
	function automatic logic [8:0] slew_exp(input logic [7:0] s, input logic w);
		return w ? 9'h1FF : {s[7:2], s[1], 1'b0, s[0]};
	endfunction : slew_exp

	function automatic logic [4:0] run_exp(input logic [7:0] s, input logic ss, input logic bs);
		return {s[7:5], 2'b11} & ~(s[4:0] & {ss, ss, ss, bs, bs});
	endfunction : run_exp

	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic hdr(input logic [7:0] cmd);
		i_cgn_host_model.start();
		i_cgn_host_model.tx(8'hD2, ack);
		i_cgn_host_model.tx(cmd, ack);
	endtask : hdr

	task automatic wr(input logic [6:0] off, input logic [7:0] dat);
		hdr({1'b1, off});
		i_cgn_host_model.tx(dat, ack);
		i_cgn_host_model.stop();
	endtask : wr

	task automatic rd(input logic [7:0] cmd, input int n);
		hdr(cmd);
		i_cgn_host_model.start();
		i_cgn_host_model.tx(8'hD3, ack);
		for (int i = 0; i < n; i++) begin
			i_cgn_host_model.rx(i == n - 1, rb[i]);
		end
		i_cgn_host_model.stop();
	endtask : rd

	// Output toggles seen on the link clock after the settings have crossed
	task automatic meas(output logic [4:0] tg);
		logic [4:0] p;
		repeat (8) @(negedge lclk);
		p = oc;
		tg = 5'h00;
		repeat (16) begin
			@(negedge lclk);
			tg = tg | (oc ^ p);
			p = oc;
		end
	endtask : meas

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	initial begin
		#2000000;
		err_count++;
		$display("ERROR %0t watchdog expired", $time);
		test_done();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		wl = 1'b0;
		sstop_n = 1'b1;
		bstop_n = 1'b1;
		ex = '{8'h00, {REV, MAKER}, 8'h0F, 8'hE0, 8'h00, 8'hB7};
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		check({1'b0, hsw, ssw, dsw, stsw}, 9'h000);
		check({rsl, qsl, usl}, 9'h16D);
		rd(8'h86, 6);
		for (int i = 0; i < 6; i++) begin
			check({1'b0, rb[i]}, {1'b0, ex[i]});
		end
		$display("test reset values done");
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 8'hFF : 8'($random(seed));
			d = (k == 0) ? 8'h00 : 8'($random(seed));
			wr(CGN_OFF_AMP, v);
			check({1'b0, hsw, ssw, dsw, stsw}, {1'b0, v});
			wr(CGN_OFF_SLEW, d);
			check({rsl, qsl, usl}, slew_exp(d, 1'b0));
			wr(CGN_OFF_ID, ~d);
			wr(CGN_OFF_RSVD, ~d);
			rd(8'h86, 6);
			check({1'b0, rb[0]}, {1'b0, v});
			check({1'b0, rb[1]}, {1'b0, REV, MAKER});
			check({1'b0, rb[4]}, 9'h000);
			check({1'b0, rb[5]}, {1'b0, d});
		end
		// Block write: command, count, then data
		v = ~v;
		hdr({1'b0, CGN_OFF_AMP});
		i_cgn_host_model.tx(8'h01, ack);
		i_cgn_host_model.tx(v, ack);
		i_cgn_host_model.stop();
		check({1'b0, hsw, ssw, dsw, stsw}, {1'b0, v});
		rd(8'hA0, 1);
		check({1'b0, rb[0]}, 9'h000);
		$display("test register access done");
		@(negedge clk) wl = 1'b1;
		repeat (8) @(negedge clk);
		check({rsl, qsl, usl}, 9'h1FF);
		wl = 1'b0;
		repeat (8) @(negedge clk);
		check({rsl, qsl, usl}, slew_exp(d, 1'b0));
		$display("test wireless mode done");
		wr(CGN_OFF_LEN, 8'h03);
		rd(8'h06, 5);
		ex = '{8'h03, v, {REV, MAKER}, 8'h03, CGN_IDLE_BYTE, 8'h00};
		for (int i = 0; i < 5; i++) begin
			check({1'b0, rb[i]}, {1'b0, ex[i]});
		end
		$display("test block read done");
		for (int k = 0; k < 6; k++) begin
			b = (k == 0) ? 8'hFF : (k == 1) ? 8'h1F : 8'($random(seed));
			wr(CGN_OFF_SRC, b);
			@(negedge clk);
			sstop_n = (k < 2) ? 1'b0 : 1'($random(seed));
			bstop_n = (k < 2) ? 1'b0 : 1'($random(seed));
			meas(t);
			check({4'h0, t}, {4'h0, run_exp(b, ~sstop_n, ~bstop_n)});
		end
		$display("test output gating done");
		test_done();
	end
endmodule : test_cgn_config_bank
